// ==== hdl/adc_seq_pkg.sv ====
// constants, register map and state carrier of the converter sequencer
// assumes one 20 MHz bus clock and a plain strobe register port
// Contract
// - no trigger: one sequence, or scan repeats
// - edge trigger: one sequence per active edge
// - level trigger: convert while trigger active
// - trigger comes from channel 7 pin
// - edge during conversion sets overrun flag
// - trigger starts conversion within one cycle; code: sampling starts three cycles after the pin
// - trigger enabled: software start ignored
// - level mode never raises overrun
// - level still active at end restarts
// - pins feed mux; buffer enable gates port
// - stop, wait-stop or power-down enter low power
// - power-up bit resets to zero
// - low power aborts running sequence
// - recovery period after power-up before converting
// - sequence-complete interrupt, enabled and cpu-masked
// - 8 or 10 bit binary search
// - exactly one channel to sample stage
// - two sample stages: buffer then direct
// - sample and convert clocks gated idle
// - done flag x set at conversion x
// - port reads pin or 1; resets 1
package adc_seq_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CHANNELS = 8;
  localparam int CODE_W = 10;

  localparam logic [3:0] ADDR_CTRL_TWO = 4'h0;
  localparam logic [3:0] ADDR_CTRL_THREE = 4'h1;
  localparam logic [3:0] ADDR_SEQ_START = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_DONE_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_DIG_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_DIG_PORT = 4'h6;
  localparam logic [3:0] ADDR_RESULT_BASE = 4'h8;

  // field positions
  localparam int CT2_POWER_UP = 0;
  localparam int CT2_WAIT_STOP = 1;
  localparam int CT2_IRQ_EN = 2;
  localparam int CT3_RES10 = 3;
  localparam int CT3_TRIG_EN = 4;
  localparam int CT3_TRIG_LEVEL = 5;
  localparam int CT3_TRIG_POL = 6;
  localparam int SS_MULTI = 3;
  localparam int SS_SCAN = 4;
  localparam int ST_SEQ_DONE = 0;
  localparam int ST_OVERRUN = 1;
  localparam int TRIG_CHANNEL = 7;

  // timing
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int RECOVERY_TIME_NS = 20000;
  localparam int RECOVERY_CYCLES = (RECOVERY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] SAMPLE1_CYCLES = 4'h2;
  localparam logic [3:0] SAMPLE2_CYCLES = 4'h4;
  localparam logic [3:0] COMPARE_CYCLES = 4'h3;
  localparam logic [3:0] MSB_BIT = 4'h9;
  localparam logic [3:0] LSB_BIT_10 = 4'h0;
  localparam logic [3:0] LSB_BIT_8 = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SAMPLE1 = 3'b001,
    ST_SAMPLE2 = 3'b010,
    ST_CONVERT = 3'b011,
    ST_STORE = 3'b100
  } seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [2:0] chan;
    logic [2:0] pos;
    logic [3:0] bitn;
    logic [9:0] code;
    logic [3:0] wait_cnt;
    logic [15:0] recov;
    logic power_up;
    logic wait_stop;
    logic irq_en;
    logic [2:0] seq_len_m1;
    logic res10;
    logic trig_en;
    logic trig_level;
    logic trig_pol;
    logic [2:0] start_chan;
    logic multi;
    logic scan;
    logic seq_done;
    logic overrun;
    logic [7:0] done_flags;
    logic [7:0] dien;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic comp_s1;
    logic comp_s2;
    logic trig_prev;
    logic [7:0][9:0] result;
    logic [15:0] rdata;
    logic irq;
    logic sclk_en;
    logic cclk_en;
    logic amp;
    logic direct;
    logic pwr;
    logic [2:0] mux_sel;
    logic [9:0] dac;
  } seq_regs_t;
endpackage : adc_seq_pkg

// ==== hdl/adc_sequencer_trigger_control.sv ====
// digital control of an 8-channel multiplexed successive-approximation converter
// assumes analog front end answers on comparator_i; pins and comparator are asynchronous
`timescale 1ns/1ps
module adc_sequencer_trigger_control #(
  parameter int RECOVERY = adc_seq_pkg::RECOVERY_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [adc_seq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [adc_seq_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [adc_seq_pkg::DATA_W-1:0] rdata_o,
  // system
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  input wire logic cpu_irq_mask_i,
  output logic seq_complete_irq_o,
  // pins and analog front end
  input wire logic [adc_seq_pkg::CHANNELS-1:0] pin_level_i,
  input wire logic comparator_i,
  output logic analog_power_o,
  output logic sample_clk_en_o,
  output logic convert_clk_en_o,
  output logic sample_amp_o,
  output logic sample_direct_o,
  output logic [2:0] mux_sel_o,
  output logic [adc_seq_pkg::CODE_W-1:0] dac_code_o
);

  adc_seq_pkg::seq_regs_t r;
  adc_seq_pkg::seq_regs_t n;

  function automatic logic [15:0] recov_load();
    recov_load = 16'(RECOVERY);
  endfunction : recov_load

  // state groups shared by outputs and trigger checks
  function automatic logic is_sampling(input adc_seq_pkg::seq_state_t s);
    is_sampling = (s == adc_seq_pkg::ST_SAMPLE1) || (s == adc_seq_pkg::ST_SAMPLE2);
  endfunction : is_sampling

  function automatic logic is_busy(input adc_seq_pkg::seq_state_t s);
    is_busy = (s != adc_seq_pkg::ST_IDLE);
  endfunction : is_busy

  // active level of the trigger pin after polarity
  function automatic logic active_level(input logic lvl, input logic pol);
    active_level = pol ? lvl : ~lvl;
  endfunction : active_level

  // last bit of the binary search for the chosen width
  function automatic logic [3:0] last_bit(input logic res10);
    last_bit = res10 ? adc_seq_pkg::LSB_BIT_10 : adc_seq_pkg::LSB_BIT_8;
  endfunction : last_bit

  // right justified result word
  function automatic logic [9:0] justify(input logic res10, input logic [9:0] code);
    justify = res10 ? code : {2'b00, code[9:2]};
  endfunction : justify

  // channel of the next conversion in a sequence
  function automatic logic [2:0] next_channel(input logic multi, input logic [2:0] chan);
    next_channel = multi ? chan + 3'h1 : chan;
  endfunction : next_channel

  logic trig_act;
  logic trig_edge;
  logic low_power;
  logic ready;
  logic sw_start;
  logic trg_start;
  logic start;
  logic wr_hit_start;
  logic [3:0] stop_bit;
  logic [9:0] res_val;

  // per-pin digital path: buffer on reads the pin, off reads one
  logic [adc_seq_pkg::CHANNELS-1:0] port_bits;

  for (genvar g = 0; g < adc_seq_pkg::CHANNELS; g++) begin : g_port
    assign port_bits[g] = r.dien[g] ? r.pin_s2[g] : 1'b1;
  end

  always_comb begin
    n = r;
    trig_act = 1'b0;
    trig_edge = 1'b0;
    low_power = 1'b0;
    ready = 1'b0;
    sw_start = 1'b0;
    trg_start = 1'b0;
    start = 1'b0;
    wr_hit_start = 1'b0;
    stop_bit = adc_seq_pkg::LSB_BIT_8;
    res_val = 10'h000;

    // synchronisers
    // pins and comparator are asynchronous: two flops each
    n.pin_s1 = pin_level_i;
    n.pin_s2 = r.pin_s1;
    n.comp_s1 = comparator_i;
    n.comp_s2 = r.comp_s1;

    // trigger detection on the synchronised channel 7 pin
    // prev holds the polarised level, so a polarity write can look like an edge
    trig_act = active_level(r.pin_s2[adc_seq_pkg::TRIG_CHANNEL], r.trig_pol);
    n.trig_prev = trig_act;
    trig_edge = trig_act & ~r.trig_prev;

    low_power = stop_mode_i | (wait_mode_i & r.wait_stop) | ~r.power_up;
    // recovery reloads every low-power cycle and counts down after wake
    // nothing converts or triggers until it reaches zero
    if (low_power) begin
      n.recov = recov_load();
    end else if (r.recov != 16'h0000) begin
      n.recov = r.recov - 16'h0001;
    end
    ready = ~low_power & (r.recov == 16'h0000);

    // register writes
    // registers stay writable in every low-power state
    if (wr_i) begin
      unique case (addr_i)
        adc_seq_pkg::ADDR_CTRL_TWO: begin
          n.power_up = wdata_i[adc_seq_pkg::CT2_POWER_UP];
          n.wait_stop = wdata_i[adc_seq_pkg::CT2_WAIT_STOP];
          n.irq_en = wdata_i[adc_seq_pkg::CT2_IRQ_EN];
        end
        adc_seq_pkg::ADDR_CTRL_THREE: begin
          n.seq_len_m1 = wdata_i[2:0];
          n.res10 = wdata_i[adc_seq_pkg::CT3_RES10];
          n.trig_en = wdata_i[adc_seq_pkg::CT3_TRIG_EN];
          n.trig_level = wdata_i[adc_seq_pkg::CT3_TRIG_LEVEL];
          n.trig_pol = wdata_i[adc_seq_pkg::CT3_TRIG_POL];
        end
        adc_seq_pkg::ADDR_SEQ_START: begin
          n.start_chan = wdata_i[2:0];
          n.multi = wdata_i[adc_seq_pkg::SS_MULTI];
          n.scan = wdata_i[adc_seq_pkg::SS_SCAN];
          wr_hit_start = 1'b1;
        end
        adc_seq_pkg::ADDR_STATUS: begin
          // write one to clear
          if (wdata_i[adc_seq_pkg::ST_SEQ_DONE]) begin
            n.seq_done = 1'b0;
          end
          if (wdata_i[adc_seq_pkg::ST_OVERRUN]) begin
            n.overrun = 1'b0;
          end
        end
        adc_seq_pkg::ADDR_DIG_ENABLE: begin
          n.dien = wdata_i[7:0];
        end
        default: begin
        end
      endcase
    end

    // reading a result clears its done flag
    // a store in the same cycle wins: the set comes later below
    if (rd_i && addr_i[3]) begin
      n.done_flags[addr_i[2:0]] = 1'b0;
    end

    // software start refused while triggered, powering or recovering
    sw_start = wr_hit_start & ~r.trig_en & ready;
    // level mode restarts from idle while the level stays active
    if (r.trig_en && ready && r.st == adc_seq_pkg::ST_IDLE) begin
      trg_start = r.trig_level ? trig_act : trig_edge;
    end
    start = sw_start | trg_start;

    // further active edges while busy in edge mode
    // level mode never counts re-assertion as overrun
    if (r.trig_en && !r.trig_level && ready && trig_edge && is_busy(r.st)) begin
      n.overrun = 1'b1;
    end

    stop_bit = last_bit(r.res10);
    res_val = justify(r.res10, r.code);

    unique case (r.st)
      adc_seq_pkg::ST_IDLE: begin
      end
      adc_seq_pkg::ST_SAMPLE1: begin
        // buffer amplifier charges the storage node
        if (r.wait_cnt == 4'h0) begin
          n.st = adc_seq_pkg::ST_SAMPLE2;
          n.wait_cnt = adc_seq_pkg::SAMPLE2_CYCLES - 4'h1;
        end else begin
          n.wait_cnt = r.wait_cnt - 4'h1;
        end
      end
      adc_seq_pkg::ST_SAMPLE2: begin
        // input tied directly to the node
        if (r.wait_cnt == 4'h0) begin
          n.st = adc_seq_pkg::ST_CONVERT;
          n.bitn = adc_seq_pkg::MSB_BIT;
          n.code = 10'h200;
          n.wait_cnt = adc_seq_pkg::COMPARE_CYCLES - 4'h1;
        end else begin
          n.wait_cnt = r.wait_cnt - 4'h1;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (r.wait_cnt == 4'h0) begin
          // comparator seen through two flops; three cycles per bit cover it
          // comparator high: sample at or above trial level, keep bit
          if (!r.comp_s2) begin
            n.code[r.bitn] = 1'b0;
          end
          if (r.bitn == stop_bit) begin
            n.st = adc_seq_pkg::ST_STORE;
          end else begin
            n.bitn = r.bitn - 4'h1;
            n.code[r.bitn - 4'h1] = 1'b1;
            n.wait_cnt = adc_seq_pkg::COMPARE_CYCLES - 4'h1;
          end
        end else begin
          n.wait_cnt = r.wait_cnt - 4'h1;
        end
      end
      adc_seq_pkg::ST_STORE: begin
        // result slot follows sequence position, not channel
        n.result[r.pos] = res_val;
        n.done_flags[r.pos] = 1'b1;
        if (r.pos == r.seq_len_m1) begin
          n.seq_done = 1'b1;
          // scan only without trigger; a trigger ends each sequence in idle
          if (r.scan && !r.trig_en) begin
            n.st = adc_seq_pkg::ST_SAMPLE1;
            n.pos = 3'h0;
            n.chan = r.start_chan;
            n.wait_cnt = adc_seq_pkg::SAMPLE1_CYCLES - 4'h1;
          end else begin
            n.st = adc_seq_pkg::ST_IDLE;
          end
        end else begin
          n.st = adc_seq_pkg::ST_SAMPLE1;
          n.pos = r.pos + 3'h1;
          n.chan = next_channel(r.multi, r.chan);
          n.wait_cnt = adc_seq_pkg::SAMPLE1_CYCLES - 4'h1;
        end
      end
      default: begin
        n.st = adc_seq_pkg::ST_IDLE;
      end
    endcase

    // a start restarts any running sequence
    // done flags cleared; overrun cleared by a software start, not by a trigger start
    if (start) begin
      n.st = adc_seq_pkg::ST_SAMPLE1;
      n.chan = n.start_chan;
      n.pos = 3'h0;
      n.done_flags = 8'h00;
      n.wait_cnt = adc_seq_pkg::SAMPLE1_CYCLES - 4'h1;
      if (sw_start) begin
        n.overrun = 1'b0;
      end
    end

    // low power overrides any start in the same cycle
    if (low_power) begin
      n.st = adc_seq_pkg::ST_IDLE;
    end

    // read data, one cycle after the strobe
    // stands one cycle, zero otherwise
    n.rdata = 16'h0000;
    if (rd_i) begin
      if (addr_i[3]) begin
        n.rdata = {6'h00, r.result[addr_i[2:0]]};
      end else begin
        unique case (addr_i)
          adc_seq_pkg::ADDR_CTRL_TWO: begin
            n.rdata = {13'h0000, r.irq_en, r.wait_stop, r.power_up};
          end
          adc_seq_pkg::ADDR_CTRL_THREE: begin
            n.rdata = {9'h000, r.trig_pol, r.trig_level, r.trig_en, r.res10, r.seq_len_m1};
          end
          adc_seq_pkg::ADDR_SEQ_START: begin
            n.rdata = {11'h000, r.scan, r.multi, r.start_chan};
          end
          adc_seq_pkg::ADDR_STATUS: begin
            n.rdata = {14'h0000, r.overrun, r.seq_done};
          end
          adc_seq_pkg::ADDR_DONE_FLAGS: begin
            n.rdata = {8'h00, r.done_flags};
          end
          adc_seq_pkg::ADDR_DIG_ENABLE: begin
            n.rdata = {8'h00, r.dien};
          end
          adc_seq_pkg::ADDR_DIG_PORT: begin
            n.rdata = {8'h00, port_bits};
          end
          default: begin
            n.rdata = 16'h0000;
          end
        endcase
      end
    end

    // registered outputs follow the next state
    // so every port comes from a flop with no extra lag
    // interrupt follows the mask level one cycle later
    n.irq = n.seq_done & n.irq_en & ~cpu_irq_mask_i;
    n.sclk_en = is_sampling(n.st);
    n.cclk_en = (n.st == adc_seq_pkg::ST_CONVERT);
    n.amp = (n.st == adc_seq_pkg::ST_SAMPLE1);
    n.direct = (n.st == adc_seq_pkg::ST_SAMPLE2);
    n.pwr = ~low_power;
    n.mux_sel = n.chan;
    n.dac = (n.st == adc_seq_pkg::ST_CONVERT) ? n.code : 10'h000;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // state, power and recovery come up cleared: powered down
      // pin sync flops reset high so the port reads ones
      r <= '0;
      r.power_up <= 1'b0;
      r.pin_s1 <= 8'hff;
      r.pin_s2 <= 8'hff;
      r.rdata <= 16'h0000;
      r.recov <= 16'h0000;
    end else begin
      r <= n;
    end
  end

  // ports straight from flops
  assign rdata_o = r.rdata;
  assign seq_complete_irq_o = r.irq;
  assign analog_power_o = r.pwr;
  assign sample_clk_en_o = r.sclk_en;
  assign convert_clk_en_o = r.cclk_en;
  assign sample_amp_o = r.amp;
  assign sample_direct_o = r.direct;
  assign mux_sel_o = r.mux_sel;
  assign dac_code_o = r.dac;

endmodule : adc_sequencer_trigger_control

// ==== dv/adc_seq_properties.sv ====
// port assertions for the converter sequencer
// assumes a bind onto the sequencer top, one clock domain
`timescale 1ns/1ps
module adc_seq_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // system
  input wire logic stop_mode_i,
  input wire logic cpu_irq_mask_i,
  input wire logic seq_complete_irq_o,
  // front end
  input wire logic analog_power_o,
  input wire logic sample_clk_en_o,
  input wire logic convert_clk_en_o,
  input wire logic sample_amp_o,
  input wire logic sample_direct_o,
  input wire logic [2:0] mux_sel_o,
  input wire logic [9:0] dac_code_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence buffer_stage;
    (sample_amp_o && !sample_direct_o) [*2];
  endsequence
  sequence direct_stage;
    (sample_direct_o && !sample_amp_o) [*4];
  endsequence
  a_sample_two_stages: assert property ($rose(sample_amp_o) |-> buffer_stage ##1 direct_stage ##1 convert_clk_en_o)
    else $error("sample stages out of order");
  a_sample_clk_gate: assert property (sample_clk_en_o == (sample_amp_o || sample_direct_o))
    else $error("sample clock not gated");
  a_convert_idle_dac: assert property (!convert_clk_en_o |-> dac_code_o == 10'h000)
    else $error("trial code outside conversion");
  a_trial_msb_first: assert property ($rose(convert_clk_en_o) |-> dac_code_o == 10'h200)
    else $error("search not started at midscale");
  a_mux_held: assert property (sample_direct_o || convert_clk_en_o |-> $stable(mux_sel_o))
    else $error("channel changed in conversion");
  a_power_reset_off: assert property ($fell(rst_i) |-> !analog_power_o)
    else $error("powered after reset");
  a_stop_aborts: assert property (stop_mode_i [*3] |-> !analog_power_o && !sample_clk_en_o && !convert_clk_en_o)
    else $error("stop did not abort");
  a_irq_masked: assert property ($rose(cpu_irq_mask_i) |=> !seq_complete_irq_o)
    else $error("interrupt not masked");
endmodule : adc_seq_properties

bind adc_sequencer_trigger_control adc_seq_properties adc_seq_properties_inst (.clock_i, .rst_i, .stop_mode_i,
  .cpu_irq_mask_i, .seq_complete_irq_o, .analog_power_o, .sample_clk_en_o, .convert_clk_en_o, .sample_amp_o,
  .sample_direct_o, .mux_sel_o, .dac_code_o);

// ==== dv/adc_front_model.sv ====
// front end model: pin levels, trigger source, comparator
// assumes trial code and channel select straight from the sequencer
`timescale 1ns/1ps
module adc_front_model (
  // from bench
  input wire logic trig_i,
  input wire logic [6:0] pins_i,
  // from sequencer
  input wire logic [2:0] mux_sel_i,
  input wire logic [9:0] dac_code_i,
  // to sequencer
  output logic [7:0] pin_level_o,
  output logic comparator_o
);
  assign pin_level_o = {trig_i, pins_i};
  // channel x sits at level x*100+37
  assign comparator_o = (10'(mux_sel_i) * 10'h064 + 10'h025) >= dac_code_i;
endmodule : adc_front_model

// ==== dv/adc_sequencer_trigger_control_test.sv ====
// bench for the converter sequencer: register tasks and sequence tests
// assumes the front end model on pins and comparator
`timescale 1ns/1ps
module adc_sequencer_trigger_control_test;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0, rd_i = 1'b0, stop_mode_i = 1'b0, wait_mode_i = 1'b0, cpu_irq_mask_i = 1'b0, trig = 1'b0;
  logic [6:0] pins = 7'h5a;
  logic [15:0] rdata_o;
  logic [7:0] pin_level_i;
  logic [2:0] mux_sel_o;
  logic [9:0] dac_code_o;
  logic seq_complete_irq_o, comparator_i, analog_power_o, sample_clk_en_o, convert_clk_en_o;
  logic sample_amp_o, sample_direct_o;
  int num_errors = 0;
  int check_count = 0;
  always #25 clock_i = ~clock_i;
  adc_sequencer_trigger_control #(.RECOVERY(4)) adc_sequencer_trigger_control_inst (.clock_i, .rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .stop_mode_i, .wait_mode_i, .cpu_irq_mask_i, .seq_complete_irq_o,
    .pin_level_i, .comparator_i, .analog_power_o, .sample_clk_en_o, .convert_clk_en_o, .sample_amp_o,
    .sample_direct_o, .mux_sel_o, .dac_code_o);
  adc_front_model adc_front_model_inst (.trig_i(trig), .pins_i(pins), .mux_sel_i(mux_sel_o),
    .dac_code_i(dac_code_o), .pin_level_o(pin_level_i), .comparator_o(comparator_i));
  task final_report;
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task peek(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
    @(posedge clock_i);
  endtask : peek
  task rd(input logic [3:0] a, input logic [15:0] e, input string n);
    logic [15:0] v;
    peek(a, v);
    chk(n, v, e);
  endtask : rd
  // poll status until a sequence has completed
  task wait_done;
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 60 && v[0] !== 1'b1; i++) peek(4'h3, v);
    chk("seq_done", {15'h0, v[0]}, 16'h0001);
  endtask : wait_done
  task idle_chk;
    repeat (60) @(negedge clock_i);
    chk("busy", {15'h0, convert_clk_en_o}, 16'h0000);
  endtask : idle_chk
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(4'h0, 16'h0000, "ctrl2");
    rd(4'h6, 16'h00ff, "port");
    rd(4'h7, 16'h0000, "unmapped");
    wr(4'h5, 16'h000f);
    rd(4'h6, 16'h00fa, "port");
    wr(4'h0, 16'h0005);
    repeat (8) @(posedge clock_i);
    wr(4'h1, 16'h0008);
    wr(4'h2, 16'h0002);
    wait_done;
    chk("irq", {15'h0, seq_complete_irq_o}, 16'h0001);
    rd(4'h4, 16'h0001, "flags");
    rd(4'h8, 16'h00ed, "result0");
    @(posedge clock_i);
    cpu_irq_mask_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    chk("irq", {15'h0, seq_complete_irq_o}, 16'h0000);
    @(posedge clock_i);
    cpu_irq_mask_i <= 1'b0;
    wr(4'h3, 16'h0003);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h000d);
    wait_done;
    rd(4'h4, 16'h0003, "flags");
    rd(4'h8, 16'h0086, "result0");
    rd(4'h9, 16'h009f, "result1");
    idle_chk;
    wr(4'h3, 16'h0003);
    wr(4'h1, 16'h0058);
    wr(4'h2, 16'h0002);
    repeat (60) @(negedge clock_i);
    rd(4'h3, 16'h0000, "status");
    @(posedge clock_i);
    trig <= 1'b1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk("amp", {15'h0, sample_amp_o}, 16'h0001);
    repeat (15) @(posedge clock_i);
    trig <= 1'b0;
    repeat (4) @(posedge clock_i);
    trig <= 1'b1;
    wait_done;
    rd(4'h3, 16'h0003, "status");
    wr(4'h3, 16'h0003);
    rd(4'h3, 16'h0000, "status");
    wr(4'h1, 16'h0018);
    trig <= 1'b0;
    wait_done;
    wr(4'h3, 16'h0003);
    for (int p = 0; p < 2; p++) begin
      wr(4'h1, p ? 16'h0078 : 16'h0038);
      trig <= p[0];
      wait_done;
      wr(4'h3, 16'h0003);
      trig <= ~p[0];
      @(posedge clock_i);
      trig <= p[0];
      wait_done;
      rd(4'h3, 16'h0001, "status");
      trig <= ~p[0];
      wr(4'h3, 16'h0003);
      idle_chk;
    end
    wr(4'h1, 16'h0008);
    wr(4'h0, 16'h0007);
    repeat (8) @(posedge clock_i);
    for (int i = 0; i < 3; i++) begin
      wr(4'h3, 16'h0003);
      wr(4'h2, 16'h0012);
      wait_done;
      wr(4'h3, 16'h0003);
      wait_done;
      repeat (15) @(posedge clock_i);
      stop_mode_i <= (i == 0);
      wait_mode_i <= (i == 1);
      if (i == 2) wr(4'h0, 16'h0006);
      repeat (4) @(negedge clock_i);
      chk("clocks", {14'h0, sample_clk_en_o, convert_clk_en_o}, 16'h0000);
      chk("power", {15'h0, analog_power_o}, 16'h0000);
      rd(4'h1, 16'h0008, "ctrl3");
      stop_mode_i <= 1'b0;
      wait_mode_i <= 1'b0;
      wr(4'h0, 16'h0007);
      idle_chk;
    end
    final_report;
  end
endmodule : adc_sequencer_trigger_control_test
